//--- rtl/flm_ctrl.sv
/*
 flash led mode control: wishbone register file, standby/torch/flash state,
 flash safety timer, supply monitor fallback and fault flags.
 assumes async strobe pin and analog comparator inputs; one 250 MHz clock.
*/
`timescale 1ns/1ps
module flm_ctrl
   import flm_pkg::*;
#(
   parameter int unsigned STEP_CYC = TMO_STEP_CYC,
   parameter int unsigned RAMP_CYC = RAMP_STEP_CYC
) (
   // clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   // wishbone slave
   input  wire logic               cyc_i,
   input  wire logic               stb_i,
   input  wire logic               we_i,
   input  wire logic [7:0]         adr_i,
   input  wire logic [3:0]         sel_i,
   input  wire logic [31:0]        dat_i,
   output logic [31:0]             dat_o,
   output logic                    ack_o,
   // pins and analog status
   input  wire logic               strobe_trigger_pin_i,
   input  wire logic               vin_low_i,
   input  wire logic               ilim_hit_i,
   // driver commands
   output logic [2:0]              vin_thresh_o,
   output flm_pkg::flm_state_e     mode_o,
   output flm_pkg::flm_chan_s [1:0] chan_o
);
   import flm_pkg::*;

   localparam int unsigned SW = (STEP_CYC > 1) ? $clog2(STEP_CYC) : 1;

   generate
      if (STEP_CYC < 2) begin : g_bad
         $error("flm_ctrl: STEP_CYC must be at least 2");
      end
   endgenerate

   // byte address of a register index
   function automatic logic hit(input logic [7:0] adr, input logic [7:0] idx);
      hit = (adr == {idx[5:0], 2'b00});
   endfunction

   logic [7:0]    cur_ff;
   logic [4:0]    tmo_ff;
   logic [2:0]    vmon_ff;
   logic [7:0]    cfg_ff;
   logic [7:0]    ctl_ff;
   logic          stat_tmo_ff;
   logic          stat_vin_ff;
   logic          flt_ocp_ff;
   logic          ack_ff;
   logic          wr_go;
   logic [7:0]    wdat;
   logic [2:0]    strobe_trigger_pin_sync_ff;
   logic [2:0]    vin_sync_ff;
   logic [1:0]    ilim_sync_ff;
   logic          strobe_trigger_pin_s;
   logic          strobe_trigger_pin_rise;
   logic          vin_low_s;
   logic          vin_cross;
   flm_state_e    state_ff;
   flm_state_e    nxt_state;
   logic [SW-1:0] sub_ff;
   logic [4:0]    step_ff;
   logic          expire;
   logic          fb_ff;
   logic          en;
   logic          sel;
   logic          strobe_trigger_pin_mode;
   logic          vmon_en;
   logic          torch_cond;
   logic          flash_end;
   logic [3:0]    ramp_lvl;
   logic [31:0]   len_ff;

   assign en        = ctl_ff[CTL_EN_BIT];
   assign sel       = ctl_ff[CTL_SEL_BIT];
   assign strobe_trigger_pin_mode = cfg_ff[CFG_STROBE_TRIGGER_PIN_BIT];
   assign vmon_en   = cfg_ff[CFG_VMON_BIT];

   // bus: ack one cycle after the request, writes land on the ack edge
   assign ack_o = ack_ff;
   assign wr_go = cyc_i && stb_i && we_i && ack_ff && sel_i[0];
   assign wdat  = dat_i[7:0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= cyc_i && stb_i && !ack_ff;
      end
   end

   // read data captured with ack; unmapped reads answer zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (cyc_i && stb_i && !ack_ff) begin
         dat_o <= 32'h0000_0000;
         if (hit(adr_i, REG_CUR)) dat_o[7:0] <= cur_ff;
         if (hit(adr_i, REG_TMO)) dat_o[4:0] <= tmo_ff;
         if (hit(adr_i, REG_VMON)) dat_o[2:0] <= vmon_ff;
         if (hit(adr_i, REG_CFG)) dat_o[7:0] <= cfg_ff;
         if (hit(adr_i, REG_CTL)) dat_o[7:0] <= ctl_ff;
         if (hit(adr_i, REG_STAT)) begin
            dat_o[STAT_TMO_BIT] <= stat_tmo_ff;
            dat_o[STAT_VIN_BIT] <= stat_vin_ff;
         end
         if (hit(adr_i, REG_FLT)) dat_o[FLT_OCP_BIT] <= flt_ocp_ff;
         if (hit(adr_i, REG_MODE)) dat_o[1:0] <= state_ff;
      end
   end

   // software-written configuration
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur_ff  <= CUR_RST;
         tmo_ff  <= TMO_RST;
         vmon_ff <= VMON_RST;
         cfg_ff  <= CFG_RST;
         ctl_ff  <= CTL_RST;
      end else if (wr_go) begin
         if (hit(adr_i, REG_CUR)) cur_ff <= wdat;
         if (hit(adr_i, REG_TMO)) tmo_ff <= wdat[4:0];
         if (hit(adr_i, REG_VMON)) vmon_ff <= wdat[2:0];
         if (hit(adr_i, REG_CFG)) cfg_ff <= wdat;
         if (hit(adr_i, REG_CTL)) ctl_ff <= wdat;
      end
   end

   // threshold code goes straight to the comparator trim
   assign vin_thresh_o = vmon_ff;

   // pin synchronisers; third stage only feeds edge detection
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strobe_trigger_pin_sync_ff <= 3'h0;
         vin_sync_ff  <= 3'h0;
         ilim_sync_ff <= 2'h0;
      end else begin
         strobe_trigger_pin_sync_ff <= {strobe_trigger_pin_sync_ff[1:0], strobe_trigger_pin_i};
         vin_sync_ff  <= {vin_sync_ff[1:0], vin_low_i};
         ilim_sync_ff <= {ilim_sync_ff[0], ilim_hit_i};
      end
   end

   assign strobe_trigger_pin_s    = strobe_trigger_pin_sync_ff[1];
   assign strobe_trigger_pin_rise = strobe_trigger_pin_sync_ff[1] && !strobe_trigger_pin_sync_ff[2];
   assign vin_low_s = vin_sync_ff[1];
   assign vin_cross = vin_sync_ff[1] && !vin_sync_ff[2];

   // mode selection
   assign torch_cond = en && !sel && (!strobe_trigger_pin_mode || strobe_trigger_pin_s);
   assign expire = (state_ff == FLM_FLASH) && (step_ff == tmo_ff)
                   && (sub_ff == SW'(STEP_CYC - 1));

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         FLM_IDLE: begin
            if (!en) begin
               nxt_state = FLM_IDLE;
            end else if (strobe_trigger_pin_mode) begin
               if (strobe_trigger_pin_s && !sel) nxt_state = FLM_TORCH;
               else if (strobe_trigger_pin_rise && sel) nxt_state = FLM_FLASH;
            end else begin
               nxt_state = sel ? FLM_FLASH : FLM_TORCH;
            end
         end
         FLM_TORCH: begin
            if (!torch_cond) nxt_state = FLM_IDLE;
         end
         FLM_FLASH: begin
            if (!en) nxt_state = FLM_IDLE;
            else if (expire) nxt_state = FLM_DONE;
            else if (strobe_trigger_pin_mode && !strobe_trigger_pin_s) nxt_state = FLM_IDLE;
            else if (!strobe_trigger_pin_mode && !sel) nxt_state = FLM_IDLE;
         end
         FLM_DONE: begin
            // held off until the request goes away, so one flash per request
            if (!en || !sel || (strobe_trigger_pin_mode && !strobe_trigger_pin_s)) nxt_state = FLM_IDLE;
         end
         default: nxt_state = FLM_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= FLM_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign mode_o    = state_ff;
   assign flash_end = (state_ff == FLM_FLASH) && (nxt_state != FLM_FLASH);

   // safety timer, cleared whenever no flash runs
   always_ff @(posedge clk_i) begin
      if (rst_i || state_ff != FLM_FLASH) begin
         sub_ff  <= '0;
         step_ff <= 5'h00;
      end else if (sub_ff == SW'(STEP_CYC - 1)) begin
         sub_ff  <= '0;
         step_ff <= step_ff + 5'h01;
      end else begin
         sub_ff <= sub_ff + 1'b1;
      end
   end

   // supply fallback latch, lives for one flash only
   always_ff @(posedge clk_i) begin
      if (rst_i || state_ff != FLM_FLASH) begin
         fb_ff <= 1'b0;
      end else if (vmon_en && vin_low_s) begin
         fb_ff <= 1'b1;
      end
   end

   // sticky flags, write one to clear, a set in the same cycle wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_tmo_ff <= 1'b0;
         stat_vin_ff <= 1'b0;
         flt_ocp_ff  <= 1'b0;
      end else begin
         stat_tmo_ff <= flash_end || (stat_tmo_ff
            && !(wr_go && hit(adr_i, REG_STAT) && wdat[STAT_TMO_BIT]));
         stat_vin_ff <= (vmon_en && vin_cross) || (stat_vin_ff
            && !(wr_go && hit(adr_i, REG_STAT) && wdat[STAT_VIN_BIT]));
         flt_ocp_ff <= (state_ff == FLM_FLASH && ilim_sync_ff[1]) || (flt_ocp_ff
            && !(wr_go && hit(adr_i, REG_FLT) && wdat[FLT_OCP_BIT]));
      end
   end

   flm_ramp #(
      .STEP_CYC (RAMP_CYC)
   ) u_ramp (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .run_i    (state_ff == FLM_TORCH || fb_ff),
      .target_i (cur_ff[CUR_TORCH_LSB +: 4]),
      .level_o  (ramp_lvl)
   );

   // both channels take the same command
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < 2; i++) begin
         if (rst_i || state_ff == FLM_IDLE || state_ff == FLM_DONE) begin
            chan_o[i] <= '0;
         end else if (state_ff == FLM_TORCH || fb_ff) begin
            chan_o[i] <= '{on: 1'b1, flash: 1'b0, code: ramp_lvl};
         end else begin
            chan_o[i] <= '{on: 1'b1, flash: 1'b1, code: cur_ff[CUR_FLASH_LSB +: 4]};
         end
      end
   end

   // helper: cycles spent in the current flash
   always_ff @(posedge clk_i) begin
      if (rst_i || state_ff != FLM_FLASH) begin
         len_ff <= 32'h0000_0000;
      end else begin
         len_ff <= len_ff + 32'h0000_0001;
      end
   end

   // checks sample on the block clock and stay muted while reset is held
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_flash_code_out: assert property (
      state_ff == FLM_FLASH && !fb_ff |=> chan_o[0].flash
         && chan_o[0].code == $past(cur_ff[3:0]))
      else $error("flash code not driven in flash");
   chk_timeout_length: assert property (
      expire |-> len_ff == (32'(tmo_ff) + 32'h1) * 32'(STEP_CYC) - 32'h1)
      else $error("flash timeout length wrong");
   chk_tmo_flag_set: assert property (
      flash_end |=> stat_tmo_ff && (ctl_ff == $past(ctl_ff) || $past(wr_go)))
      else $error("timeout flag not set or enable changed");
   chk_strobe_tmo_end: assert property (
      expire && en && strobe_trigger_pin_mode && strobe_trigger_pin_s |=> state_ff == FLM_DONE && stat_tmo_ff)
      else $error("strobe flash did not end at timeout");
   chk_vin_fallback: assert property (
      state_ff == FLM_FLASH && vmon_en && vin_low_s |=> fb_ff ##1 !chan_o[0].flash
         || state_ff != FLM_FLASH)
      else $error("no torch fallback on low supply");
   chk_vmon_reset: assert property (
      $fell(rst_i) |-> vmon_ff == VMON_RST && vin_thresh_o == 3'h4)
      else $error("monitor threshold reset value wrong");
   chk_vin_flag_set: assert property (
      vmon_en && vin_cross |=> stat_vin_ff)
      else $error("input voltage fault flag not set");
   chk_torch_code_out: assert property (
      state_ff == FLM_TORCH |=> !chan_o[0].flash && chan_o[0].code == $past(ramp_lvl))
      else $error("torch code not driven in torch");
   chk_reg_flash_entry: assert property (
      state_ff == FLM_IDLE && !strobe_trigger_pin_mode && en && sel |=> state_ff == FLM_FLASH)
      else $error("register flash not entered");
   chk_standby_disable: assert property (
      !en |=> state_ff == FLM_IDLE ##1 !chan_o[0].on)
      else $error("disabled driver not in standby");
   chk_strobe_low_idle: assert property (
      en && strobe_trigger_pin_mode && !strobe_trigger_pin_s |=> state_ff != FLM_TORCH && state_ff != FLM_FLASH)
      else $error("low strobe did not hold standby");
   chk_chan_match: assert property (
      state_ff != FLM_IDLE |=> chan_o[0] == chan_o[1])
      else $error("channels disagree");
   chk_ilim_flag_set: assert property (
      state_ff == FLM_FLASH && ilim_sync_ff[1] |=> flt_ocp_ff)
      else $error("current limit flag not set");
   chk_timer_restart: assert property (
      state_ff != FLM_FLASH |=> sub_ff == '0 && step_ff == 5'h00)
      else $error("timeout counter runs outside flash");
   // entry, timer scope and the dark done state; done must not relight the leds
   chk_strobe_flash_entry: assert property (
      state_ff == FLM_IDLE && en && strobe_trigger_pin_mode && sel && strobe_trigger_pin_rise |=> state_ff == FLM_FLASH)
      else $error("strobe rising edge did not start flash");
   chk_torch_untimed: assert property (
      state_ff == FLM_TORCH |=> state_ff != FLM_DONE)
      else $error("torch was ended by the flash timer");
   chk_done_chan_off: assert property (
      state_ff == FLM_DONE |=> !chan_o[0].on && !chan_o[1].on)
      else $error("channels still on after timeout");
   chk_timer_from_zero: assert property (
      $rose(state_ff == FLM_FLASH) |-> sub_ff == '0 && step_ff == 5'h00)
      else $error("timeout counter did not start from zero");
endmodule

//--- rtl/flm_pkg.sv
/*
 flash led mode control: shared constants, state and channel types.
 assumes a single 250 MHz clock; registers sit at word index * 4 on the bus.
*/
package flm_pkg;
   // clock rate and the times derived from it
   localparam int unsigned CLK_MHZ      = 250;
   localparam int unsigned TMO_STEP_MS  = 32;
   localparam int unsigned TMO_STEP_CYC = TMO_STEP_MS * 1000 * CLK_MHZ;
   localparam int unsigned RAMP_STEP_NS = 1000;
   localparam int unsigned RAMP_STEP_CYC = (RAMP_STEP_NS * CLK_MHZ) / 1000;

   // register indices, byte address is index * 4
   localparam logic [7:0] REG_CUR  = 8'h06;
   localparam logic [7:0] REG_TMO  = 8'h07;
   localparam logic [7:0] REG_VMON = 8'h08;
   localparam logic [7:0] REG_CFG  = 8'h09;
   localparam logic [7:0] REG_CTL  = 8'h0A;
   localparam logic [7:0] REG_STAT = 8'h0B;
   localparam logic [7:0] REG_FLT  = 8'h10;
   localparam logic [7:0] REG_MODE = 8'h11;

   // field positions
   localparam int unsigned CUR_FLASH_LSB = 0;
   localparam int unsigned CUR_TORCH_LSB = 4;
   localparam int unsigned CFG_VMON_BIT  = 0;
   localparam int unsigned CFG_STROBE_TRIGGER_PIN_BIT  = 4;
   localparam int unsigned CTL_EN_BIT    = 1;
   localparam int unsigned CTL_SEL_BIT   = 2;
   localparam int unsigned STAT_TMO_BIT  = 1;
   localparam int unsigned STAT_VIN_BIT  = 4;
   localparam int unsigned FLT_OCP_BIT   = 1;

   // values after reset
   localparam logic [7:0] CUR_RST  = 8'h00;
   localparam logic [4:0] TMO_RST  = 5'h0F;
   localparam logic [2:0] VMON_RST = 3'h4;
   localparam logic [7:0] CFG_RST  = 8'h00;
   localparam logic [7:0] CTL_RST  = 8'h00;

   // driver operating state
   typedef enum logic [1:0] {FLM_IDLE, FLM_TORCH, FLM_FLASH, FLM_DONE} flm_state_e;

   // per-channel current command
   typedef struct packed {
      logic       on;
      logic       flash;
      logic [3:0] code;
   } flm_chan_s;
endpackage

//--- rtl/flm_ramp.sv
/*
 torch current ramp: walks the level one code at a time toward the target.
 assumes run_i and target_i come from logic on the same clock.
*/
`timescale 1ns/1ps
module flm_ramp #(
   parameter int unsigned STEP_CYC = 250
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // control
   input  wire logic       run_i,
   input  wire logic [3:0] target_i,
   // ramped level
   output logic [3:0]      level_o
);
   localparam int unsigned CW = (STEP_CYC > 1) ? $clog2(STEP_CYC) : 1;

   generate
      if (STEP_CYC < 1) begin : g_bad
         $error("flm_ramp: STEP_CYC must be at least 1");
      end
   endgenerate

   logic [CW-1:0] cnt_ff;
   logic          tick;

   assign tick = (cnt_ff == CW'(STEP_CYC - 1));

   // step divider, held at zero while idle so each ramp starts fresh
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i || tick) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   // one code per step, never a jump to the full level
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         level_o <= 4'h0;
      end else if (tick && level_o < target_i) begin
         level_o <= level_o + 4'h1;
      end else if (tick && level_o > target_i) begin
         level_o <= level_o - 4'h1;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_ramp_single_step: assert property (
      $past(run_i) && run_i |-> level_o == $past(level_o)
         || level_o == $past(level_o) + 4'h1 || level_o == $past(level_o) - 4'h1)
      else $error("torch level moved by more than one code");
endmodule

//--- tb/flm_host.sv
/*
 host model: classic wishbone master and strobe pin driver.
 assumes one clock shared with the block; the ack comes back registered.
*/
`timescale 1ns/1ps
module flm_host (
   // clock and bus answer
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   input  wire logic [31:0] dat_i,
   // bus request
   output logic             cyc_o,
   output logic             stb_o,
   output logic             we_o,
   output logic [7:0]       adr_o,
   output logic [3:0]       sel_o,
   output logic [31:0]      dat_o,
   // strobe pin
   output logic             strobe_o
);
   // idle bus and low pin at time zero
   initial begin
      {cyc_o, stb_o, we_o, strobe_o} = 4'h0;
      adr_o = 8'h00;
      sel_o = 4'h0;
      dat_o = 32'h0;
   end

   // one classic cycle; released lines flip so stale values cannot pass
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] s, output logic [7:0] q, output logic to);
      int n;
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o  <= w;
      adr_o <= a;
      sel_o <= s;
      dat_o <= {24'h0, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_i !== 1'b1 && n < 64);
      q = dat_i[7:0];
      to = (n >= 64);
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      adr_o <= ~a;
      dat_o <= ~{24'h0, d};
   endtask

   // pin level changes just after an edge
   task automatic pin(input logic v);
      @(posedge clk_i);
      strobe_o <= v;
   endtask
endmodule

//--- tb/testbench.sv
/*
 bench for the flash led mode control block: host model on bus and strobe,
 bench drives the supply and current-limit comparators.
 assumes shortened timeout and ramp steps set through parameters.
*/
`timescale 1ns/1ps
module testbench;
   import flm_pkg::*;
   localparam int unsigned ST = 20; // short timeout step keeps runs brief
   localparam logic [7:0] RA [9] = '{REG_CUR, REG_TMO, REG_VMON, REG_CFG, REG_CTL,
                                     REG_STAT, REG_FLT, REG_MODE, 8'h00};
   localparam logic [7:0] RV [9] = '{CUR_RST, {3'h0, TMO_RST}, {5'h0, VMON_RST}, CFG_RST,
                                     CTL_RST, 8'h00, 8'h00, 8'h00, 8'h00};
   // clock, reset and block ports
   logic            clk_i = 1'b0;
   logic            rst_i = 1'b1;
   logic            vin_low_i = 1'b0;
   logic            ilim_hit_i = 1'b0;
   logic            cyc_i, stb_i, we_i, ack_o, strobe_i, to;
   logic [7:0]      adr_i, q, c;
   logic [3:0]      sel_i;
   logic [31:0]     dat_i, dat_o;
   logic [2:0]      vin_thresh_o;
   flm_state_e      mode_o;
   flm_chan_s [1:0] chan_o;
   logic [7:0]      exp_q[$];
   int              n_errors = 0;
   int              tests_run = 0;
   int              fcnt = 0;

   always #2 clk_i = ~clk_i;

   flm_ctrl #(.STEP_CYC(ST), .RAMP_CYC(2)) uut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .strobe_trigger_pin_i(strobe_i), .vin_low_i(vin_low_i), .ilim_hit_i(ilim_hit_i),
      .vin_thresh_o(vin_thresh_o), .mode_o(mode_o), .chan_o(chan_o));

   flm_host host (
      .clk_i(clk_i), .ack_i(ack_o), .dat_i(dat_o), .cyc_o(cyc_i), .stb_o(stb_i),
      .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i), .strobe_o(strobe_i));

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e);
      end
   endtask

   task automatic close_out();
      if (n_errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // reads note the expected byte before the request goes out
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] s);
      if (!w) begin
         exp_q.push_back(d);
      end
      host.wb(w, {a[5:0], 2'b00}, d, s, q, to);
      if (to) begin
         n_errors++;
         close_out();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, e, 4'hF);
   endtask

   task automatic wait_mode(input flm_state_e m);
      int n;
      n = 0;
      while (mode_o !== m && n < 2000) begin
         @(posedge clk_i);
         n++;
      end
      chk(32'(mode_o), 32'(m));
      if (mode_o !== m) begin
         close_out();
      end
   endtask

   // read answers taken off the queue at the ack edge
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && we_i === 1'b0) begin
         chk(dat_o, (exp_q.size() > 0) ? {24'h0, exp_q.pop_front()} : 32'hDEAD);
      end
   end

   // flash length in cycles, zeroed by the sequence only while idle
   always @(posedge clk_i) begin
      if (mode_o === FLM_FLASH) begin
         fcnt <= fcnt + 1;
      end
   end

   initial begin
      void'($urandom(93));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk(32'(vin_thresh_o), 32'h4);
      for (int i = 0; i < 9; i++) begin
         rd(RA[i], RV[i]);
      end
      for (int i = 0; i < 4; i++) begin
         c = 8'($urandom);
         wr(REG_CUR, c);
         bus(1'b1, REG_CUR, ~c, 4'hE);
         rd(REG_CUR, c);
         wr(REG_TMO, c & 8'h1F);
         rd(REG_TMO, c & 8'h1F);
         wr(REG_VMON, c & 8'h07);
         rd(REG_VMON, c & 8'h07);
         chk(32'(vin_thresh_o), 32'(c[2:0]));
      end
      // register torch: stepped ramp, same on both channels
      wr(REG_CUR, 8'h5A);
      wr(REG_CTL, 8'h02);
      wait_mode(FLM_TORCH);
      repeat (2) @(posedge clk_i);
      chk(32'(chan_o[0].code < 4'h5), 32'h1);
      repeat (40) @(posedge clk_i);
      chk(32'(chan_o), {20'h0, 6'h25, 6'h25});
      rd(REG_MODE, 8'h01);
      wr(REG_CTL, 8'h00);
      wait_mode(FLM_IDLE);
      // register flash twice: timer restarts each time
      wr(REG_TMO, 8'h01);
      for (int k = 0; k < 2; k++) begin
         fcnt = 0;
         wr(REG_CTL, 8'h06);
         wait_mode(FLM_FLASH);
         repeat (2) @(posedge clk_i);
         chk(32'(chan_o), {20'h0, 6'h3A, 6'h3A});
         wait_mode(FLM_DONE);
         chk(32'(fcnt), 32'(2 * ST));
         repeat (2) @(posedge clk_i);
         chk(32'(chan_o), 32'h0);
         rd(REG_STAT, 8'h02);
         rd(REG_CTL, 8'h06);
         wr(REG_STAT, 8'h02);
         wr(REG_CTL, 8'h00);
         wait_mode(FLM_IDLE);
      end
      // strobe mode: low pin idle, held pin cut at the timeout, torch on level
      wr(REG_CFG, 8'h10);
      wr(REG_CTL, 8'h06);
      repeat (6) @(posedge clk_i);
      chk(32'(mode_o), 32'(FLM_IDLE));
      fcnt = 0;
      host.pin(1'b1);
      wait_mode(FLM_FLASH);
      wait_mode(FLM_DONE);
      chk(32'(fcnt), 32'(2 * ST));
      rd(REG_STAT, 8'h02);
      host.pin(1'b0);
      wait_mode(FLM_IDLE);
      wr(REG_STAT, 8'h02);
      wr(REG_CTL, 8'h02);
      host.pin(1'b1);
      wait_mode(FLM_TORCH);
      host.pin(1'b0);
      wait_mode(FLM_IDLE);
      wr(REG_CTL, 8'h00);
      // current limit outside flash is ignored
      @(posedge clk_i);
      ilim_hit_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      ilim_hit_i <= 1'b0;
      rd(REG_FLT, 8'h00);
      // supply drop and current limit during a long flash
      wr(REG_TMO, 8'h0F);
      wr(REG_CFG, 8'h01);
      wr(REG_CTL, 8'h06);
      wait_mode(FLM_FLASH);
      vin_low_i <= 1'b1;
      ilim_hit_i <= 1'b1;
      repeat (40) @(posedge clk_i);
      chk(32'(chan_o), {20'h0, 6'h25, 6'h25});
      chk(32'(mode_o), 32'(FLM_FLASH));
      rd(REG_STAT, 8'h10);
      rd(REG_FLT, 8'h02);
      vin_low_i <= 1'b0;
      ilim_hit_i <= 1'b0;
      wait_mode(FLM_DONE);
      rd(REG_STAT, 8'h12);
      close_out();
   end
endmodule
